// file: hw/gim_pkg.sv
package gim_pkg;
    localparam logic [7:0] GIM_ADDR_STATUS = 8'h41;
    localparam logic [7:0] GIM_ADDR_DEVICE = 8'h42;
    localparam logic [7:0] GIM_ADDR_LEVEL = 8'h43;
    localparam logic [7:0] GIM_ADDR_UC_MASK = 8'h44;
    localparam logic [7:0] GIM_ADDR_M12_MASK = 8'h45;
    localparam logic [7:0] GIM_ADDR_M3_MASK = 8'h46;
    // status bit positions
    localparam int GIM_ST_UC = 7;
    localparam int GIM_ST_M1 = 6;
    localparam int GIM_ST_M2 = 5;
    localparam int GIM_ST_M3 = 4;
    localparam int GIM_ST_THERM = 3;
    localparam int GIM_ST_SUPV = 2;
    localparam int GIM_ST_SYNC = 1;
    localparam int GIM_ST_PIN = 0;
    // user card mask bit positions
    localparam int GIM_UC_EARLY = 7;
    localparam int GIM_UC_NOANS = 6;
    localparam int GIM_UC_PROTECTION_FAULT_EVENT = 5;
    localparam int GIM_UC_SYNC = 4;
    localparam int GIM_UC_THERM = 3;
    localparam int GIM_UC_SUPV = 2;
    localparam int GIM_UC_PINALL = 1;
    localparam int GIM_UC_PRES = 0;
    // module one-two and module three mask positions
    localparam int GIM_M1_EARLY = 7;
    localparam int GIM_M2_EARLY = 4;
    localparam int GIM_MOD_SUPPLY = 1;
    localparam int GIM_USER_SUPPLY = 0;
    localparam int GIM_M3_EARLY = 7;
    localparam int GIM_PIN_MASK_LSB = 1;
    // level register layout and direction field in device register
    localparam int GIM_LVL_IN_LSB = 4;
    localparam int GIM_DIR_LSB = 2;
    localparam logic [3:0] GIM_OUT_RESET = 4'hf;
    localparam logic [3:0] GIM_DIR_RESET = 4'h0;
    localparam logic [7:0] GIM_MASK_RESET = 8'h00;
    localparam logic [7:0] GIM_STATUS_RESET = 8'h00;
endpackage : gim_pkg

// file: hw/gim_regs.sv
`timescale 1ns/10ps
module gim_regs
    import gim_pkg::*;
(
    input wire logic mclk, // 125 MHz clock
    input wire logic rst, // sync reset, high
    input wire logic [7:0] reg_addr, // register address
    input wire logic reg_wr, // write strobe
    input wire logic [7:0] reg_wdata, // write data
    input wire logic reg_rd, // read strobe
    output logic [7:0] reg_rdata, // read data, next cycle
    input wire logic [2:0] uc_event, // user card early, no-answer, protection
    input wire logic uc_supply_fail, // user card supply failure
    input wire logic card_presence_change, // user card presence change
    input wire logic [2:0] secure_module_1, // early, no-answer, protection
    input wire logic [2:0] secure_module_2, // early, no-answer, protection
    input wire logic [2:0] secure_module_3, // early, no-answer, protection
    input wire logic [2:0] mod_supply_fail, // supply failure per module
    input wire logic thermal_event, // all cards off, over temperature
    input wire logic supervisor_fault, // all cards off, supply supervisor
    input wire logic sync_complete, // sync activation done
    input wire logic [3:0] pin_sense, // pin 4..1 pad levels
    output logic [3:0] pin_drive, // pin 4..1 drive levels
    output logic [3:0] pin_oe, // pin 4..1 drive enables
    output logic int_n // interrupt, low active
);
    logic [3:0] pin_meta_ff, pin_sync_ff, pin_prev_ff;
    logic [3:0] pin_level_out_ff, dir_ff;
    logic [7:0] uc_mask_ff, m12_mask_ff, m3_mask_ff, status_ff, rdata_ff;

    wire wr_level = reg_wr && reg_addr == GIM_ADDR_LEVEL;
    wire wr_dev = reg_wr && reg_addr == GIM_ADDR_DEVICE;
    wire wr_uc = reg_wr && reg_addr == GIM_ADDR_UC_MASK;
    wire wr_m12 = reg_wr && reg_addr == GIM_ADDR_M12_MASK;
    wire wr_m3 = reg_wr && reg_addr == GIM_ADDR_M3_MASK;
    wire rd_status = reg_rd && reg_addr == GIM_ADDR_STATUS;

    wire uc_hit = |(uc_event & ~uc_mask_ff[GIM_UC_EARLY -: 3])
        || (card_presence_change && !uc_mask_ff[GIM_UC_PRES])
        || (uc_supply_fail && !m12_mask_ff[GIM_USER_SUPPLY]);
    wire [8:0] mod_fault = {secure_module_1, secure_module_2, secure_module_3};
    wire [8:0] mod_fault_mask = {m12_mask_ff[GIM_M1_EARLY -: 3], m12_mask_ff[GIM_M2_EARLY -: 3],
        m3_mask_ff[GIM_M3_EARLY -: 3]};
    // modules 1..3 land on status bits 6..4, high slice first
    wire [2:0] mod_hit;
    genvar g;
    generate
        for (g = 0; g < 3; g = g + 1) begin : g_mod
            assign mod_hit[2 - g] = |(mod_fault[8 - 3 * g -: 3] & ~mod_fault_mask[8 - 3 * g -: 3])
                || (mod_supply_fail[g] && !m12_mask_ff[GIM_MOD_SUPPLY]);
        end
    endgenerate
    wire therm_hit = thermal_event && !uc_mask_ff[GIM_UC_THERM];
    wire supv_hit = supervisor_fault && !uc_mask_ff[GIM_UC_SUPV];
    wire sync_hit = sync_complete && !uc_mask_ff[GIM_UC_SYNC];
    // only pins set as input report changes
    wire [3:0] pin_change = (pin_sync_ff ^ pin_prev_ff) & dir_ff;
    wire pin_hit = !uc_mask_ff[GIM_UC_PINALL]
        && |(pin_change & ~m3_mask_ff[GIM_PIN_MASK_LSB +: 4]);
    wire [7:0] status_set = {uc_hit, mod_hit, therm_hit, supv_hit, sync_hit, pin_hit};
    // set wins over the read clear so no event is lost
    wire [7:0] nxt_status = (rd_status ? 8'h00 : status_ff) | status_set;

    // live levels in upper nibble, reserved device bits read zero
    wire [7:0] rd_mux = reg_addr == GIM_ADDR_STATUS ? status_ff
        : reg_addr == GIM_ADDR_DEVICE ? {2'b00, dir_ff, 2'b00}
        : reg_addr == GIM_ADDR_LEVEL ? {pin_sync_ff, pin_level_out_ff}
        : reg_addr == GIM_ADDR_UC_MASK ? uc_mask_ff
        : reg_addr == GIM_ADDR_M12_MASK ? m12_mask_ff
        : reg_addr == GIM_ADDR_M3_MASK ? {m3_mask_ff[7:1], 1'b0}
        : 8'h00;

    // two stages before any logic sees a pin
    always_ff @(posedge mclk) begin
        if (rst) begin
            pin_meta_ff <= 4'h0;
            pin_sync_ff <= 4'h0;
            pin_prev_ff <= 4'h0;
        end else begin
            pin_meta_ff <= pin_sense;
            pin_sync_ff <= pin_meta_ff;
            pin_prev_ff <= pin_sync_ff;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            pin_level_out_ff <= GIM_OUT_RESET;
            dir_ff <= GIM_DIR_RESET;
        end else begin
            // only the low nibble is writable
            if (wr_level) pin_level_out_ff <= reg_wdata[3:0];
            if (wr_dev) dir_ff <= reg_wdata[GIM_DIR_LSB +: 4];
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            uc_mask_ff <= GIM_MASK_RESET;
            m12_mask_ff <= GIM_MASK_RESET;
            m3_mask_ff <= GIM_MASK_RESET;
        end else begin
            if (wr_uc) uc_mask_ff <= reg_wdata;
            if (wr_m12) m12_mask_ff <= reg_wdata;
            if (wr_m3) m3_mask_ff <= {reg_wdata[7:1], 1'b0};
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            status_ff <= GIM_STATUS_RESET;
            rdata_ff <= 8'h00;
        end else begin
            status_ff <= nxt_status;
            if (reg_rd) rdata_ff <= rd_mux;
        end
    end

    assign reg_rdata = rdata_ff;
    assign pin_drive = pin_level_out_ff;
    assign pin_oe = ~dir_ff;
    // low while any summary bit set
    assign int_n = ~|status_ff;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    // read of the summary clears it and lets the interrupt go
    sequence s_status_read;
        rd_status && status_set == 8'h00;
    endsequence

    sequence s_status_empty;
        status_ff == 8'h00 ##0 int_n;
    endsequence

    // thermal mask lifted, then one cycle without a mask write
    sequence s_mask_lifted;
        wr_uc && !reg_wdata[GIM_UC_THERM] ##1 !wr_uc;
    endsequence

    // an unmasked change seen on an input pin
    sequence s_pin_moves;
        ((pin_sync_ff ^ pin_prev_ff) & dir_ff & ~m3_mask_ff[GIM_PIN_MASK_LSB +: 4]) != 4'h0;
    endsequence

    // register path
    a_level_readback: assert property (
        reg_rd && reg_addr == GIM_ADDR_LEVEL |=> reg_rdata == {$past(pin_sync_ff), $past(pin_level_out_ff)})
        else $error("level read does not show pins");

    a_output_write: assert property (
        wr_level |=> pin_drive == $past(reg_wdata[3:0]))
        else $error("output bits not taken from write");

    a_input_undriven: assert property (
        wr_dev |=> pin_oe == ~$past(reg_wdata[GIM_DIR_LSB +: 4]))
        else $error("input pin driven");

    a_dir_readback: assert property (
        reg_rd && reg_addr == GIM_ADDR_DEVICE |=> reg_rdata == {2'b00, ~$past(pin_oe), 2'b00})
        else $error("direction read does not match drive");

    a_mask_bit_unused: assert property (
        reg_rd && reg_addr == GIM_ADDR_M3_MASK |=> !reg_rdata[0])
        else $error("unused mask bit reads one");

    a_uc_mask_store: assert property (
        wr_uc |=> uc_mask_ff == $past(reg_wdata))
        else $error("user card mask not stored");

    a_m12_mask_store: assert property (
        wr_m12 |=> m12_mask_ff == $past(reg_wdata))
        else $error("module one two mask not stored");

    a_m3_mask_store: assert property (
        wr_m3 |=> m3_mask_ff[7:1] == $past(reg_wdata[7:1]) && !m3_mask_ff[0])
        else $error("module three mask not stored");

    // masked sources stay silent
    a_user_gate: assert property (
        uc_event != 3'h0 && (uc_event & ~uc_mask_ff[GIM_UC_EARLY -: 3]) == 3'h0 && !card_presence_change
            && !uc_supply_fail && !status_ff[GIM_ST_UC] |=> !status_ff[GIM_ST_UC])
        else $error("masked user card fault reported");

    a_presence_gate: assert property (
        card_presence_change && uc_mask_ff[GIM_UC_PRES] && uc_event == 3'h0 && !uc_supply_fail
            && !status_ff[GIM_ST_UC] |=> !status_ff[GIM_ST_UC])
        else $error("masked presence change reported");

    a_user_supply: assert property (
        uc_supply_fail && m12_mask_ff[GIM_USER_SUPPLY] && uc_event == 3'h0 && !card_presence_change
            && !status_ff[GIM_ST_UC] |=> !status_ff[GIM_ST_UC])
        else $error("masked user supply failure reported");

    a_module1_gate: assert property (
        secure_module_1 != 3'h0 && (secure_module_1 & ~m12_mask_ff[GIM_M1_EARLY -: 3]) == 3'h0
            && !mod_supply_fail[0] && !status_ff[GIM_ST_M1] |=> !status_ff[GIM_ST_M1])
        else $error("masked module 1 fault reported");

    a_module2_gate: assert property (
        secure_module_2 != 3'h0 && (secure_module_2 & ~m12_mask_ff[GIM_M2_EARLY -: 3]) == 3'h0
            && !mod_supply_fail[1] && !status_ff[GIM_ST_M2] |=> !status_ff[GIM_ST_M2])
        else $error("masked module 2 fault reported");

    a_module3_gate: assert property (
        secure_module_3 != 3'h0 && (secure_module_3 & ~m3_mask_ff[GIM_M3_EARLY -: 3]) == 3'h0
            && !mod_supply_fail[2] && !status_ff[GIM_ST_M3] |=> !status_ff[GIM_ST_M3])
        else $error("masked module 3 fault reported");

    a_module_supply: assert property (
        m12_mask_ff[GIM_MOD_SUPPLY] && secure_module_2 == 3'h0 && !status_ff[GIM_ST_M2] |=> !status_ff[GIM_ST_M2])
        else $error("masked module supply failure reported");

    a_sync_gate: assert property (
        sync_complete && uc_mask_ff[GIM_UC_SYNC] && !status_ff[GIM_ST_SYNC] |=> !status_ff[GIM_ST_SYNC])
        else $error("masked sync event reported");

    a_thermal_gate: assert property (
        uc_mask_ff[GIM_UC_THERM] && !status_ff[GIM_ST_THERM] |=> !status_ff[GIM_ST_THERM])
        else $error("masked thermal event reported");

    a_supervisor_gate: assert property (
        uc_mask_ff[GIM_UC_SUPV] && !status_ff[GIM_ST_SUPV] |=> !status_ff[GIM_ST_SUPV])
        else $error("masked supervisor event reported");

    a_pin_global: assert property (
        uc_mask_ff[GIM_UC_PINALL] && !status_ff[GIM_ST_PIN] |=> !status_ff[GIM_ST_PIN])
        else $error("pin change passed global mask");

    a_pin_each: assert property (
        ((pin_sync_ff ^ pin_prev_ff) & ~m3_mask_ff[GIM_PIN_MASK_LSB +: 4]) == 4'h0 && !status_ff[GIM_ST_PIN] |=> !status_ff[GIM_ST_PIN])
        else $error("masked pin change reported");

    // unmasked sources set their summary bit next cycle
    a_user_reaches: assert property (
        (uc_event & ~uc_mask_ff[GIM_UC_EARLY -: 3]) != 3'h0 |=> status_ff[GIM_ST_UC] && !int_n)
        else $error("user card fault lost");

    a_presence_reaches: assert property (
        card_presence_change && !uc_mask_ff[GIM_UC_PRES] |=> status_ff[GIM_ST_UC])
        else $error("presence change lost");

    a_user_supply_on: assert property (
        uc_supply_fail && !m12_mask_ff[GIM_USER_SUPPLY] |=> status_ff[GIM_ST_UC])
        else $error("user supply failure lost");

    a_module1_reaches: assert property (
        (secure_module_1 & ~m12_mask_ff[GIM_M1_EARLY -: 3]) != 3'h0 |=> status_ff[GIM_ST_M1])
        else $error("module 1 fault lost");

    a_module2_reaches: assert property (
        (secure_module_2 & ~m12_mask_ff[GIM_M2_EARLY -: 3]) != 3'h0 |=> status_ff[GIM_ST_M2])
        else $error("module 2 fault lost");

    a_module3_reaches: assert property (
        (secure_module_3 & ~m3_mask_ff[GIM_M3_EARLY -: 3]) != 3'h0 |=> status_ff[GIM_ST_M3])
        else $error("module 3 fault lost");

    a_module_supply_on: assert property (
        mod_supply_fail[2] && !m12_mask_ff[GIM_MOD_SUPPLY] |=> status_ff[GIM_ST_M3])
        else $error("module supply failure lost");

    a_sync_reaches: assert property (
        sync_complete && !uc_mask_ff[GIM_UC_SYNC] |=> status_ff[GIM_ST_SYNC])
        else $error("sync complete lost");

    a_supervisor_reaches: assert property (
        supervisor_fault && !uc_mask_ff[GIM_UC_SUPV] |=> status_ff[GIM_ST_SUPV])
        else $error("supervisor fault lost");

    a_pin_reaches: assert property (
        s_pin_moves ##0 !uc_mask_ff[GIM_UC_PINALL] |=> status_ff[GIM_ST_PIN])
        else $error("pin change lost");

    a_event_reaches: assert property (
        thermal_event && !uc_mask_ff[GIM_UC_THERM] |=> !int_n [*1] ##0 status_ff[GIM_ST_THERM])
        else $error("unmasked event did not raise interrupt");

    a_unmask_restores: assert property (
        s_mask_lifted ##1 thermal_event |=> status_ff[GIM_ST_THERM])
        else $error("event after unmask lost");

    // summary holds until read
    a_status_clear: assert property (
        s_status_read |=> s_status_empty)
        else $error("summary not cleared by read");

    a_status_hold: assert property (
        !rd_status |=> (status_ff & $past(status_ff)) == $past(status_ff))
        else $error("summary bit dropped without read");

    a_read_shows: assert property (
        rd_status |=> reg_rdata == $past(status_ff))
        else $error("summary read shows wrong value");
endmodule : gim_regs

// file: tb/gim_pin_model.sv
`timescale 1ns/10ps
module gim_pin_model (
    input wire logic [3:0] pin_drive, // block drive levels
    input wire logic [3:0] pin_oe, // block drive enables
    input wire logic [3:0] ext_lvl, // outside level when released
    output logic [3:0] pin_sense // resolved pad levels
);
    // the block wins where it drives; elsewhere the outside device sets the pad
    assign pin_sense = (pin_drive & pin_oe) | (ext_lvl & ~pin_oe);
endmodule : gim_pin_model

// file: tb/testbench.sv
`timescale 1ns/10ps
module testbench;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] reg_addr = 8'h00;
    logic reg_wr = 1'b0;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_rd = 1'b0;
    logic [7:0] reg_rdata;
    logic [19:0] ev = 20'h00000;
    logic [3:0] ext = 4'hf;
    logic [3:0] pin_sense, pin_drive, pin_oe;
    logic int_n;
    int error_cnt = 0;
    int checks_done = 0;
    int cyc = 0;
    // addr, mask, event index, expected status
    logic [31:0] tbl [20] = '{32'h44801380, 32'h44401280, 32'h44201180, 32'h45011080, 32'h44010f80,
        32'h45800e40, 32'h45400d40, 32'h45200c40, 32'h45100b20, 32'h45080a20, 32'h45040920, 32'h46800810,
        32'h46400710, 32'h46200610, 32'h45020340, 32'h45020420, 32'h45020510, 32'h44080208, 32'h44040104,
        32'h44100002};
    always #4 mclk = ~mclk;
    gim_regs gim_regs_i (.mclk(mclk), .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .uc_event(ev[19:17]), .uc_supply_fail(ev[16]),
        .card_presence_change(ev[15]), .secure_module_1(ev[14:12]), .secure_module_2(ev[11:9]),
        .secure_module_3(ev[8:6]), .mod_supply_fail(ev[5:3]), .thermal_event(ev[2]), .supervisor_fault(ev[1]),
        .sync_complete(ev[0]), .pin_sense(pin_sense), .pin_drive(pin_drive), .pin_oe(pin_oe), .int_n(int_n));
    gim_pin_model gim_pin_model_i (.pin_drive(pin_drive), .pin_oe(pin_oe), .ext_lvl(ext), .pin_sense(pin_sense));
    task automatic summarize;
        $display("checks %0d mismatches %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : summarize
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            error_cnt++;
            $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk) #1 reg_addr = a;
        reg_wdata = d;
        reg_wr = w;
        reg_rd = ~w;
        @(posedge mclk) #1 reg_wr = 1'b0;
        reg_rd = 1'b0;
    endtask : acc
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        acc(1'b0, a, 8'h00);
        chk(reg_rdata, exp);
    endtask : rd_chk
    task automatic pulse(input int k);
        @(posedge mclk) #1 ev[k] = 1'b1;
        @(posedge mclk) #1 ev[k] = 1'b0;
    endtask : pulse
    // hang guard, generous against roughly 280 cycles of tests
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 4000) begin
            error_cnt++;
            summarize();
        end
    end
    initial begin
        repeat (20) @(posedge mclk);
        #1 rst = 1'b0;
        chk({pin_oe, pin_drive}, 8'hff);
        chk({7'h00, int_n}, 8'h01);
        rd_chk(8'h44, 8'h00);
        rd_chk(8'h45, 8'h00);
        rd_chk(8'h46, 8'h00);
        rd_chk(8'h43, 8'hff);
        rd_chk(8'h50, 8'h00);
        $display("test reset done");
        acc(1'b1, 8'h43, 8'ha5);
        chk({4'h0, pin_drive}, 8'h05);
        repeat (3) @(posedge mclk);
        rd_chk(8'h43, 8'h55);
        acc(1'b1, 8'h44, 8'h02);
        acc(1'b1, 8'h42, 8'h3c);
        chk({4'h0, pin_oe}, 8'h00);
        rd_chk(8'h42, 8'h3c);
        ext = 4'h6;
        repeat (5) @(posedge mclk);
        chk({7'h00, int_n}, 8'h01);
        rd_chk(8'h43, 8'h65);
        rd_chk(8'h41, 8'h00);
        acc(1'b1, 8'h44, 8'h00);
        acc(1'b1, 8'h46, 8'h1e);
        ext = 4'h9;
        repeat (5) @(posedge mclk);
        chk({7'h00, int_n}, 8'h01);
        rd_chk(8'h41, 8'h00);
        acc(1'b1, 8'h46, 8'h1c);
        ext = 4'h8;
        repeat (5) @(posedge mclk);
        chk({7'h00, int_n}, 8'h00);
        rd_chk(8'h41, 8'h01);
        chk({7'h00, int_n}, 8'h01);
        $display("test pins done");
        foreach (tbl[i]) begin
            acc(1'b1, tbl[i][31:24], tbl[i][23:16]);
            pulse(int'(tbl[i][15:8]));
            chk({7'h00, int_n}, 8'h01);
            acc(1'b1, tbl[i][31:24], 8'h00);
            pulse(int'(tbl[i][15:8]));
            chk({7'h00, int_n}, 8'h00);
            rd_chk(8'h41, tbl[i][7:0]);
            chk({7'h00, int_n}, 8'h01);
        end
        $display("test events done");
        // mid-run reset must bring back the documented defaults
        @(posedge mclk) #1 rst = 1'b1;
        @(posedge mclk) #1 rst = 1'b0;
        chk({pin_oe, pin_drive}, 8'hff);
        rd_chk(8'h42, 8'h00);
        rd_chk(8'h41, 8'h00);
        $display("test second reset done");
        summarize();
    end
endmodule : testbench
